/* File: smr_params.svh */
// Purpose: constants of the sync measurement readout block
// Assumes: 40 MHz clock
// Notes:   byte addresses of the register port
`ifndef SMR_PARAMS_SVH
`define SMR_PARAMS_SVH

// ----------------------------------------------------------------
// register addresses
// ----------------------------------------------------------------
`define SMR_ADDR_CTRL      8'h41
`define SMR_ADDR_LED_CUR   8'h42
`define SMR_ADDR_START     8'h47
`define SMR_ADDR_SYNC      8'h48
`define SMR_ADDR_FIFO_LEV  8'h4B
`define SMR_ADDR_FIFO_B0   8'h4C
`define SMR_ADDR_FIFO_B1   8'h4D
`define SMR_ADDR_FIFO_B2   8'h4E
`define SMR_ADDR_FIFO_B3   8'h4F
`define SMR_ADDR_GREEN_LO  8'h56
`define SMR_ADDR_GREEN_HI  8'h57
`define SMR_ADDR_INT_CLR   8'h58

// ----------------------------------------------------------------
// fields, reset values, sizes
// ----------------------------------------------------------------
`define SMR_CTRL_INT_LSB   0
`define SMR_CTRL_RATE_LSB  2
`define SMR_GREEN_RESET    16'h0000
`define SMR_LED_RESET      8'h00
`define SMR_FIFO_DEPTH     35
`define SMR_FIFO_WM        32

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define SMR_CLK_PERIOD_NS      25
`define SMR_DEFAULT_PERIOD_NS  31250000
`define SMR_DEFAULT_PERIOD_CYC (`SMR_DEFAULT_PERIOD_NS / `SMR_CLK_PERIOD_NS)

`endif

/* File: smr_pkg.sv */
// Purpose: types of the sync measurement readout block
// Assumes: nothing
// Notes:   encodings follow declaration order
package smr_pkg;

    typedef enum logic [1:0] {
        SMR_INT_NONE,
        SMR_INT_WM,
        SMR_INT_IR,
        SMR_INT_DONE
    } smr_int_sel_t;

    typedef enum logic [2:0] {
        SMR_RATE_32,
        SMR_RATE_128,
        SMR_RATE_64,
        SMR_RATE_256,
        SMR_RATE_1024
    } smr_rate_t;

    typedef enum logic [1:0] {
        SMR_SYNC_NONE,
        SMR_SYNC_ONE,
        SMR_SYNC_RUN
    } smr_sync_t;

endpackage : smr_pkg

/* File: smr_readout.sv */
// Purpose: register file, sync pacing and sample fifo of the sensor
// Assumes: register port already decoded from the serial bus, same clock
// Notes:   sample inputs come from the converter logic on the same clock
`timescale 1ns/1ps
`include "smr_params.svh"

module smr_readout
    import smr_pkg::*;
#(
    parameter int DEFAULT_PERIOD = `SMR_DEFAULT_PERIOD_CYC,
    parameter int IVL_W          = 27
) (
    input  wire logic        clock,
    input  wire logic        nrst,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    output logic      [7:0]  reg_rdata_q,
    input  wire logic        sample_valid,
    input  wire logic [15:0] sample_green_off,
    input  wire logic [15:0] sample_green_on,
    input  wire logic        ir_thresh_evt,
    input  wire logic        meas_done_evt,
    output logic             meas_req_q,
    output logic      [7:0]  led_current_q,
    output logic             int_n_q
);

    localparam int DEPTH = `SMR_FIFO_DEPTH;

    function automatic logic [3:0] rate_shift(input smr_rate_t r);
        unique case (r)
            SMR_RATE_32:   rate_shift = 4'h5;
            SMR_RATE_128:  rate_shift = 4'h7;
            SMR_RATE_64:   rate_shift = 4'h6;
            SMR_RATE_256:  rate_shift = 4'h8;
            SMR_RATE_1024: rate_shift = 4'hA;
            default:       rate_shift = 4'h5;
        endcase
    endfunction : rate_shift

    function automatic logic [5:0] wrap_inc(input logic [5:0] p);
        wrap_inc = (p == 6'(DEPTH - 1)) ? 6'h00 : p + 6'h01;
    endfunction : wrap_inc

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    smr_int_sel_t     int_sel_q, int_sel_d;
    smr_rate_t        rate_q, rate_d;
    smr_sync_t        sync_q, sync_d;
    logic [7:0]       led_pend_q, led_pend_d, led_current_d;
    logic             start_q, start_d;
    logic [15:0]      green_q, green_d;
    logic             ir_flag_q, ir_flag_d, done_flag_q, done_flag_d;
    logic [IVL_W-1:0] ivl_q, ivl_d, period_q, period_d, ph_q, ph_d, per_use;
    logic             meas_req_d, int_n_d;
    logic [7:0]       reg_rdata_d;
    logic [31:0]      mem_q [DEPTH];
    logic [31:0]      mem_d [DEPTH];
    logic [5:0]       head_q, head_d, tail_q, tail_d, level_q, level_d;
    logic             sync_evt, start_wr, clr_rd, pop, push;

    assign sync_evt = reg_wr && reg_addr == `SMR_ADDR_SYNC && reg_wdata[0];
    assign start_wr = reg_wr && reg_addr == `SMR_ADDR_START && reg_wdata[0];
    assign clr_rd   = reg_rd && reg_addr == `SMR_ADDR_INT_CLR;
    assign pop      = reg_rd && reg_addr == `SMR_ADDR_FIFO_B3 && level_q != 6'h00;
    assign push     = sample_valid && level_q != 6'(DEPTH);

    // ----------------------------------------------------------------
    // registers, pacing and fifo next values
    // ----------------------------------------------------------------
    always_comb begin
        int_sel_d     = int_sel_q;
        rate_d        = rate_q;
        led_pend_d    = led_pend_q;
        led_current_d = led_current_q;
        start_d       = start_q;
        if (reg_wr && reg_addr == `SMR_ADDR_CTRL) begin
            int_sel_d = smr_int_sel_t'(reg_wdata[`SMR_CTRL_INT_LSB +: 2]);
            rate_d    = smr_rate_t'(reg_wdata[`SMR_CTRL_RATE_LSB +: 3]);
        end
        if (reg_wr && reg_addr == `SMR_ADDR_LED_CUR) begin
            led_pend_d = reg_wdata;
        end
        if (start_wr) begin
            start_d       = 1'b1;
            led_current_d = led_pend_q;
        end
        // set wins over the clear read
        ir_flag_d   = ir_thresh_evt | (ir_flag_q & ~clr_rd);
        done_flag_d = meas_done_evt | (done_flag_q & ~clr_rd);
        green_d = sample_valid ? sample_green_on : green_q;

        // sync pacing
        sync_d   = sync_q;
        period_d = period_q;
        ivl_d    = (ivl_q == '1) ? ivl_q : ivl_q + 1'b1;
        per_use  = (sync_q == SMR_SYNC_RUN && period_q != '0)
                 ? period_q : IVL_W'(DEFAULT_PERIOD);
        if (sync_evt) begin
            ivl_d = IVL_W'(1);                                       // sync edge counts in the interval
            if (sync_q == SMR_SYNC_NONE) begin
                sync_d = SMR_SYNC_ONE;
            end else begin
                sync_d   = SMR_SYNC_RUN;
                period_d = ivl_q >> rate_shift(rate_q);
            end
        end
        if (sync_evt) begin
            ph_d       = '0;
            meas_req_d = 1'b1;
        end else if (sync_q != SMR_SYNC_NONE && ph_q >= per_use - 1'b1) begin
            ph_d       = '0;
            meas_req_d = 1'b1;
        end else begin
            ph_d       = (sync_q != SMR_SYNC_NONE) ? ph_q + 1'b1 : ph_q;
            meas_req_d = 1'b0;
        end

        // sample fifo
        mem_d  = mem_q;
        head_d = pop ? wrap_inc(head_q) : head_q;
        tail_d = tail_q;
        if (push) begin
            mem_d[tail_q] = {sample_green_on,
                             (rate_q == SMR_RATE_1024) ? 16'h0000 : sample_green_off};
            tail_d = wrap_inc(tail_q);
        end
        level_d = level_q + 6'(push) - 6'(pop);

        unique case (int_sel_q)
            SMR_INT_NONE: int_n_d = 1'b1;
            SMR_INT_WM:   int_n_d = !(level_q >= 6'(`SMR_FIFO_WM));
            SMR_INT_IR:   int_n_d = !ir_flag_q;
            SMR_INT_DONE: int_n_d = !done_flag_q;
        endcase

        reg_rdata_d = reg_rdata_q;
        if (reg_rd) begin
            unique case (reg_addr)
                `SMR_ADDR_CTRL:     reg_rdata_d = {3'h0, rate_q, int_sel_q};
                `SMR_ADDR_LED_CUR:  reg_rdata_d = led_pend_q;
                `SMR_ADDR_START:    reg_rdata_d = {7'h00, start_q};
                `SMR_ADDR_FIFO_LEV: reg_rdata_d = {2'h0, level_q};
                `SMR_ADDR_FIFO_B0:  reg_rdata_d = mem_q[head_q][7:0];
                `SMR_ADDR_FIFO_B1:  reg_rdata_d = mem_q[head_q][15:8];
                `SMR_ADDR_FIFO_B2:  reg_rdata_d = mem_q[head_q][23:16];
                `SMR_ADDR_FIFO_B3:  reg_rdata_d = mem_q[head_q][31:24];
                `SMR_ADDR_GREEN_LO: reg_rdata_d = green_q[7:0];
                `SMR_ADDR_GREEN_HI: reg_rdata_d = green_q[15:8];
                default:            reg_rdata_d = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            int_sel_q     <= SMR_INT_NONE;
            rate_q        <= SMR_RATE_32;
            sync_q        <= SMR_SYNC_NONE;
            led_pend_q    <= `SMR_LED_RESET;
            led_current_q <= `SMR_LED_RESET;
            start_q       <= 1'b0;
            green_q       <= `SMR_GREEN_RESET;
            ir_flag_q     <= 1'b0;
            done_flag_q   <= 1'b0;
            ivl_q         <= '0;
            period_q      <= '0;
            ph_q          <= '0;
            meas_req_q    <= 1'b0;
            int_n_q       <= 1'b1;
            reg_rdata_q   <= 8'h00;
            head_q        <= '0;
            tail_q        <= '0;
            level_q       <= '0;
            for (int i = 0; i < DEPTH; i++) begin
                mem_q[i] <= '0;
            end
        end else begin
            int_sel_q     <= int_sel_d;
            rate_q        <= rate_d;
            sync_q        <= sync_d;
            led_pend_q    <= led_pend_d;
            led_current_q <= led_current_d;
            start_q       <= start_d;
            green_q       <= green_d;
            ir_flag_q     <= ir_flag_d;
            done_flag_q   <= done_flag_d;
            ivl_q         <= ivl_d;
            period_q      <= period_d;
            ph_q          <= ph_d;
            meas_req_q    <= meas_req_d;
            int_n_q       <= int_n_d;
            reg_rdata_q   <= reg_rdata_d;
            head_q        <= head_d;
            tail_q        <= tail_d;
            level_q       <= level_d;
            mem_q         <= mem_d;
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);

    sequence s_second_sync;
        sync_q == SMR_SYNC_ONE && sync_evt;
    endsequence

    a_green_capture: assert property (sample_valid |=> green_q == $past(sample_green_on))
        else $error("green count not captured");
    a_clear_read: assert property (clr_rd && !ir_thresh_evt && !meas_done_evt
            |=> !ir_flag_q && !done_flag_q)
        else $error("clear read left a flag set");
    a_rate_period: assert property (sync_evt && sync_q != SMR_SYNC_NONE
            |=> period_q == ($past(ivl_q) >> rate_shift($past(rate_q))))
        else $error("period not taken from sync interval");
    a_second_sync_run: assert property (s_second_sync |=> sync_q == SMR_SYNC_RUN)
        else $error("second sync did not switch rate");
    a_default_rate: assert property (sync_q == SMR_SYNC_ONE && !sync_evt
            && ph_q == IVL_W'(DEFAULT_PERIOD - 1) |=> meas_req_q)
        else $error("default rate tick missing");
    a_sync_start: assert property (sync_evt |=> meas_req_q && ph_q == '0)
        else $error("sync did not start a measurement");
    a_led_hold: assert property (!start_wr |=> $stable(led_current_q))
        else $error("led current changed without start");
    a_wm_level: assert property (int_sel_q == SMR_INT_WM
            |=> int_n_q == !($past(level_q) >= 6'(`SMR_FIFO_WM)))
        else $error("watermark pin wrong");
    a_full_stop: assert property (level_q == 6'(DEPTH) && !pop |=> level_q == 6'(DEPTH))
        else $error("fifo stored past full");
    a_fill_count: assert property (push && !pop && level_q == 6'(`SMR_FIFO_WM - 1)
            |=> level_q == 6'(`SMR_FIFO_WM))
        else $error("fifo level miscounted");

endmodule : smr_readout

/* File: smr_host_model.sv */
// Purpose: host bus master model on the decoded register port
// Assumes: bench calls the tasks one at a time, falling-edge drive
// Notes:   released address and data show the inverse of the last value
`timescale 1ns/1ps
module smr_host_model (
    input  wire logic       clock,
    output logic            reg_wr,
    output logic            reg_rd,
    output logic      [7:0] reg_addr,
    output logic      [7:0] reg_wdata,
    input  wire logic [7:0] reg_rdata_q
);
    initial begin
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        reg_addr  = 8'h00;
        reg_wdata = 8'h00;
    end

    // one byte write; tasks run serially so accesses never collide
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(negedge clock);
        reg_addr  = a;
        reg_wdata = v;
        reg_wr    = 1'b1;
        @(negedge clock);
        reg_wr    = 1'b0;
        reg_addr  = ~a;
        reg_wdata = ~v;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(negedge clock);
        reg_addr = a;
        reg_rd   = 1'b1;
        @(negedge clock);
        reg_rd   = 1'b0;
        reg_addr = ~a;
        v        = reg_rdata_q;
    endtask : rd

    // one fifo sample, bytes 4C..4F in order; the last read pops it
    task automatic rd_sample(output logic [31:0] s);
        logic [7:0] b0, b1, b2, b3;
        rd(8'h4C, b0);
        rd(8'h4D, b1);
        rd(8'h4E, b2);
        rd(8'h4F, b3);
        s = {b3, b2, b1, b0};
    endtask : rd_sample

    // sync command is a write of 01 to 48
    task automatic sync_cmd();
        wr(8'h48, 8'h01);
    endtask : sync_cmd
endmodule : smr_host_model

/* File: tb_top.sv */
// Purpose: self-checking bench of the readout block
// Assumes: 40 MHz clock, short default pacing period
// Notes:   samples come from the bench in place of the converter
`timescale 1ns/1ps
module tb_top;
    import smr_pkg::*;
    localparam int DP = 100;
    logic        clock = 1'b0;
    logic        nrst  = 1'b0;
    logic        reg_wr, reg_rd;
    logic [7:0]  reg_addr, reg_wdata, reg_rdata_q, led_current_q, d;
    logic        sample_valid = 1'b0, ir_thresh_evt = 1'b0, meas_done_evt = 1'b0;
    logic [15:0] sample_green_off = 16'h0000, sample_green_on = 16'h0000;
    logic        meas_req_q, int_n_q;
    logic [31:0] smp;
    int          n_mismatch = 0, check_count = 0, cyc = 0, req = 0, prev_req = 0;
    int          n_req = 0, sync = 0, prev_sync = 0;

    always #12.5 clock = ~clock;

    smr_readout #(.DEFAULT_PERIOD(DP)) i_dut (.clock(clock), .nrst(nrst), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_rdata_q(reg_rdata_q), .sample_valid(sample_valid),
        .sample_green_off(sample_green_off), .sample_green_on(sample_green_on),
        .ir_thresh_evt(ir_thresh_evt), .meas_done_evt(meas_done_evt),
        .meas_req_q(meas_req_q), .led_current_q(led_current_q), .int_n_q(int_n_q));
    smr_host_model i_host (.clock(clock), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q));

    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (meas_req_q === 1'b1) begin
            prev_req <= req;
            req      <= cyc;
            n_req    <= n_req + 1;
        end
        if (reg_wr === 1'b1 && reg_addr === 8'h48 && reg_wdata === 8'h01) begin
            prev_sync <= sync;
            sync      <= cyc;
        end
    end

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    task automatic chk(input logic ok, input string m);
        check_count++;
        if (ok !== 1'b1) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: %s", $time, m);
        end
    endtask : chk

    task automatic push(input logic [15:0] off, input logic [15:0] on);
        @(negedge clock);
        sample_valid     = 1'b1;
        sample_green_off = off;
        sample_green_on  = on;
        @(negedge clock);
        sample_valid     = 1'b0;
        sample_green_off = ~off;
        sample_green_on  = ~on;
    endtask : push

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : tally_and_finish

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_reset();
        i_host.rd(8'h56, d);
        chk(d === 8'h00 && int_n_q === 1'b1, "green or pin after reset");
        chk(led_current_q === 8'h00 && n_req == 0, "led or pacing before sync");
    endtask : t_reset

    task automatic t_green();
        push(16'hA1B2, 16'h1234);
        i_host.wr(8'h56, 8'hFF);
        i_host.rd(8'h56, d);
        chk(d === 8'h34, "green low byte");
        i_host.rd(8'h57, d);
        chk(d === 8'h12, "green high byte");
    endtask : t_green

    task automatic t_led();
        i_host.wr(8'h42, 8'h5A);
        repeat (3) @(negedge clock);
        chk(led_current_q === 8'h00, "led applied without start");
        i_host.wr(8'h47, 8'h01);
        @(negedge clock);
        chk(led_current_q === 8'h5A, "led not applied after start");
    endtask : t_led

    task automatic t_int();
        for (int i = 0; i < 2; i++) begin
            i_host.wr(8'h41, 8'(2 + i));
            @(negedge clock);
            chk(int_n_q === 1'b1, "flag set before its event");
            ir_thresh_evt = 1'b1;
            meas_done_evt = 1'b1;
            @(negedge clock);
            ir_thresh_evt = 1'b0;
            meas_done_evt = 1'b0;
            repeat (2) @(negedge clock);
            chk(int_n_q === 1'b0, "flag not raised");
            i_host.rd(8'h58, d);
            repeat (2) @(negedge clock);
            chk(int_n_q === 1'b1, "flag not cleared by read");
        end
    endtask : t_int

    task automatic t_fifo();
        i_host.wr(8'h41, 8'h01);
        for (int i = 0; i < 35; i++)
            push(16'(i), 16'(~i));
        i_host.rd(8'h4B, d);
        chk(d === 8'h23, "full level");
        chk(int_n_q === 1'b0, "watermark not low");
        i_host.rd(8'h4C, d);
        chk(d === 8'hB2, "fifo byte 0");
        i_host.rd(8'h4D, d);
        chk(d === 8'hA1, "fifo byte 1");
        i_host.rd(8'h4E, d);
        chk(d === 8'h34, "fifo byte 2");
        i_host.rd(8'h4F, d);
        chk(d === 8'h12, "fifo byte 3");
        for (int i = 0; i < 12; i++)
            i_host.rd(8'h4C + 8'(i % 4), d);
        repeat (2) @(negedge clock);
        chk(int_n_q === 1'b1, "watermark below 32");
    endtask : t_fifo

    task automatic t_sync();
        i_host.sync_cmd();
        repeat (2) @(negedge clock);
        chk(req - sync == 1, "first sync request");
        repeat (250) @(negedge clock);
        chk(req - prev_req == DP, "default period");
        repeat (6000) @(negedge clock);
        i_host.sync_cmd();
        repeat (2) @(negedge clock);
        chk(req - sync == 1, "second sync request");
        i_host.rd(8'h4B, d);
        chk(d === 8'h1F, "level before flush");
        repeat (d) i_host.rd_sample(smp);
        i_host.rd(8'h4B, d);
        chk(d === 8'h00, "fifo not flushed");
        repeat (500) @(negedge clock);
        chk(req - prev_req == (sync - prev_sync) >> 5, "paced period");
    endtask : t_sync

    task automatic t_stream();
        i_host.wr(8'h41, 8'h11);
        for (int i = 0; i < 32; i++)
            push(16'(i), 16'(16'hC000 + i));
        @(negedge clock);
        chk(int_n_q === 1'b0, "watermark after fill");
        i_host.rd(8'h4B, d);
        chk(d === 8'h20, "level at watermark");
        for (int i = 0; i < 32; i++) begin
            i_host.rd_sample(smp);
            chk(smp === {16'(16'hC000 + i), 16'h0000}, "fast mode sample");
        end
        repeat (2) @(negedge clock);
        chk(int_n_q === 1'b1, "watermark after drain");
    endtask : t_stream

    initial begin
        repeat (3) @(negedge clock);
        nrst = 1'b1;
        t_reset();
        t_green();
        t_led();
        t_int();
        t_fifo();
        t_sync();
        t_stream();
        tally_and_finish();
    end

    initial begin
        #(25 * 20000);
        n_mismatch++;
        $display("CHECK FAILED at %0t: watchdog expired", $time);
        tally_and_finish();
    end
endmodule : tb_top
